/* rtl/abort_cause_pkg.sv */
// Package of offsets, fields, reset values and states for the abort logic.
package abort_cause_pkg;

  // Register byte addresses on the Avalon bus.
  localparam logic [31:0] SDA_HOLD_OFF   = 32'h5000_157c;
  localparam logic [31:0] ABORT_CAUSE_OFF = 32'h5000_1580;
  localparam logic [31:0] CTRL_CFG_OFF   = 32'h5000_15f0;
  localparam logic [31:0] ABORT_CLR_OFF  = 32'h5000_15f4;
  localparam logic [31:0] ACTIVITY_OFF   = 32'h5000_15f8;

  // Reset values.
  localparam logic [15:0] SDA_HOLD_RST = 16'h0001;
  localparam logic [15:0] ABORT_RST    = 16'h0000;
  localparam logic [5:0]  CFG_RST      = 6'h03;

  // Abort cause flag positions.
  localparam int SLAVE_READ_CMD_MISUSE      = 15;
  localparam int SLAVE_BUS_LOST             = 14;
  localparam int SLAVE_STALE_FIFO_FLUSH     = 13;
  localparam int ARBITRATION_LOST_FLAG      = 12;
  localparam int MASTER_DISABLED_ATTEMPT    = 11;
  localparam int TENBIT_READ_NO_REPEAT      = 10;
  localparam int STARTBYTE_NO_REPEAT        = 9;
  localparam int HIGHSPEED_NO_REPEAT        = 8;
  localparam int STARTBYTE_ACKED            = 7;
  localparam int HIGHSPEED_CODE_ACKED       = 6;
  localparam int GCALL_FOLLOWED_BY_READ     = 5;
  localparam int GCALL_UNACKED              = 4;
  localparam int DATA_BYTE_UNACKED          = 3;
  localparam int TENBIT_SECOND_BYTE_UNACKED = 2;
  localparam int TENBIT_FIRST_BYTE_UNACKED  = 1;
  localparam int SEVENBIT_ADDR_UNACKED      = 0;

  // Configuration register field positions.
  localparam int CFG_MASTER_ENABLE   = 0;
  localparam int CFG_REPEAT_START    = 1;
  localparam int CFG_TENBIT_MODE     = 2;
  localparam int CFG_HIGHSPEED_MODE  = 3;
  localparam int CFG_BYTE_SELECT_A   = 4;
  localparam int CFG_GCALL_OR_SBYTE  = 5;

  // Activity register field positions.
  localparam int ACT_MASTER = 0;
  localparam int ACT_SLAVE  = 1;

  typedef enum logic [2:0] {
    M_IDLE   = 3'b000,
    M_HSCODE = 3'b001,
    M_SBYTE  = 3'b010,
    M_GCALL  = 3'b011,
    M_ADDR7  = 3'b100,
    M_ADDR1  = 3'b101,
    M_ADDR2  = 3'b110,
    M_DATA   = 3'b111
  } mst_state_e;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_TX   = 2'b01,
    S_GCD  = 2'b10
  } slv_state_e;

endpackage : abort_cause_pkg

/* rtl/i2c_tx_abort_cause_logic.sv */
// Transmit abort cause logic with SDA hold register and Avalon-MM slave.
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps

module i2c_tx_abort_cause_logic (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_B_I,
  // Avalon-MM slave
  input  wire logic [31:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Bus pins, asynchronous
  input  wire logic        SCL_I,
  input  wire logic        SDA_I,
  // Data command port strobe from the controller core
  input  wire logic        CMD_WR_I,
  input  wire logic        CMD_READ_I,
  input  wire logic        CMD_BIT9_I,
  // Master side events
  input  wire logic        MST_ACK_STB_I,
  input  wire logic        MST_ACKED_I,
  input  wire logic        MST_ARBITRATION_LOST_FLAG_I,
  input  wire logic        MST_STOP_I,
  // Slave side events
  input  wire logic        SLV_RD_REQ_I,
  input  wire logic        TXF_NOT_EMPTY_I,
  input  wire logic        SLV_TX_BIT_EN_I,
  input  wire logic        SLV_TX_BIT_I,
  input  wire logic        SLV_TX_DONE_I,
  // Results
  output logic             TRANSMIT_ABORT_EVENT_O,
  output logic             TXF_FLUSH_O,
  output logic [15:0]      SDA_HOLD_COUNT_O
);
  import abort_cause_pkg::*;

  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] hold;
    logic [5:0]  cfg;
    mst_state_e  mst;
    slv_state_e  slv;
    logic        sbyte_pend;
    logic        scl_s1;
    logic        scl_s2;
    logic        scl_prev;
    logic        sda_s1;
    logic        sda_s2;
    logic        ack;
    logic        flush;
    logic [31:0] rdata;
  } state_s;

  state_s st_ff;
  state_s nxt_st;

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic hit(input logic [31:0] addr,
                               input logic [31:0] off);
    hit = (addr == off);
  endfunction : hit

  // Low byte lanes written under byte enables; upper lanes are not stored.
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    merge16 = old;
    if (be[0]) begin
      merge16[7:0] = wd[7:0];
    end
    if (be[1]) begin
      merge16[15:8] = wd[15:8];
    end
  endfunction : merge16

  ////////////////////////////////////////////////////////////////////////////

  logic        req;
  logic        wr_go;
  logic        scl_rise;
  logic        sbyte_cause;
  logic [15:0] set;
  logic [15:0] clr;

  // One wait state per access; the answer lands on the second edge.
  assign req               = AVS_READ_I | AVS_WRITE_I;
  assign AVS_WAITREQUEST_O = req & ~st_ff.ack;
  assign AVS_READDATA_O    = st_ff.rdata;
  assign wr_go             = AVS_WRITE_I & st_ff.ack;

  assign scl_rise = st_ff.scl_s2 & ~st_ff.scl_prev;
  assign sbyte_cause = ~st_ff.cfg[CFG_REPEAT_START]
                     & st_ff.cfg[CFG_BYTE_SELECT_A]
                     & st_ff.cfg[CFG_GCALL_OR_SBYTE];

  always_comb begin
    nxt_st = st_ff;
    set    = '0;
    clr    = '0;

    // Pin synchronisers and SCL edge history.
    nxt_st.scl_s1   = SCL_I;
    nxt_st.scl_s2   = st_ff.scl_s1;
    nxt_st.scl_prev = st_ff.scl_s2;
    nxt_st.sda_s1   = SDA_I;
    nxt_st.sda_s2   = st_ff.sda_s1;

    // Bus slave.
    nxt_st.ack = req & ~st_ff.ack;
    if (req & ~st_ff.ack & AVS_READ_I) begin
      nxt_st.rdata = '0;
      if (hit(AVS_ADDRESS_I, SDA_HOLD_OFF)) begin
        nxt_st.rdata[15:0] = st_ff.hold;
      end else if (hit(AVS_ADDRESS_I, ABORT_CAUSE_OFF)) begin
        nxt_st.rdata[15:0] = st_ff.flags;
      end else if (hit(AVS_ADDRESS_I, CTRL_CFG_OFF)) begin
        nxt_st.rdata[5:0] = st_ff.cfg;
      end else if (hit(AVS_ADDRESS_I, ACTIVITY_OFF)) begin
        nxt_st.rdata[ACT_MASTER] = (st_ff.mst != M_IDLE);
        nxt_st.rdata[ACT_SLAVE]  = (st_ff.slv != S_IDLE);
      end
    end
    if (wr_go) begin
      if (hit(AVS_ADDRESS_I, SDA_HOLD_OFF)) begin
        nxt_st.hold = merge16(st_ff.hold, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      end else if (hit(AVS_ADDRESS_I, CTRL_CFG_OFF)) begin
        if (AVS_BYTEENABLE_I[0]) begin
          nxt_st.cfg = AVS_WRITEDATA_I[5:0];
        end
      end else if (hit(AVS_ADDRESS_I, ABORT_CLR_OFF)) begin
        clr = '1;
      end
    end

    // Master state machine.
    nxt_st.flush = 1'b0;
    case (st_ff.mst)
      M_IDLE: begin
        if (CMD_WR_I) begin
          if (~st_ff.cfg[CFG_MASTER_ENABLE]) begin
            set[MASTER_DISABLED_ATTEMPT] = 1'b1;
          end else if (sbyte_cause) begin
            set[STARTBYTE_NO_REPEAT] = 1'b1;
          end else if (~st_ff.cfg[CFG_REPEAT_START]
                       & st_ff.cfg[CFG_HIGHSPEED_MODE]) begin
            set[HIGHSPEED_NO_REPEAT] = 1'b1;
          end else if (~st_ff.cfg[CFG_REPEAT_START]
                       & st_ff.cfg[CFG_TENBIT_MODE] & CMD_READ_I) begin
            set[TENBIT_READ_NO_REPEAT] = 1'b1;
          end else if (st_ff.cfg[CFG_HIGHSPEED_MODE]) begin
            nxt_st.mst = M_HSCODE;
          end else if (st_ff.cfg[CFG_BYTE_SELECT_A]) begin
            nxt_st.mst = st_ff.cfg[CFG_GCALL_OR_SBYTE] ? M_SBYTE : M_GCALL;
          end else begin
            nxt_st.mst = st_ff.cfg[CFG_TENBIT_MODE] ? M_ADDR1 : M_ADDR7;
          end
        end
      end
      M_HSCODE: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            set[HIGHSPEED_CODE_ACKED] = 1'b1;
          end else begin
            nxt_st.mst = st_ff.cfg[CFG_TENBIT_MODE] ? M_ADDR1 : M_ADDR7;
          end
        end
      end
      M_SBYTE: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            set[STARTBYTE_ACKED] = 1'b1;
          end else begin
            nxt_st.mst = st_ff.cfg[CFG_TENBIT_MODE] ? M_ADDR1 : M_ADDR7;
          end
        end
      end
      M_GCALL: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            nxt_st.mst = M_DATA;
          end else begin
            set[GCALL_UNACKED] = 1'b1;
          end
        end
      end
      M_ADDR7: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            nxt_st.mst = M_DATA;
          end else begin
            set[SEVENBIT_ADDR_UNACKED] = 1'b1;
          end
        end
      end
      M_ADDR1: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            nxt_st.mst = M_ADDR2;
          end else begin
            set[TENBIT_FIRST_BYTE_UNACKED] = 1'b1;
          end
        end
      end
      M_ADDR2: begin
        if (MST_ACK_STB_I) begin
          if (MST_ACKED_I) begin
            nxt_st.mst = M_DATA;
          end else begin
            set[TENBIT_SECOND_BYTE_UNACKED] = 1'b1;
          end
        end
      end
      M_DATA: begin
        if (MST_ACK_STB_I & ~MST_ACKED_I) begin
          set[DATA_BYTE_UNACKED] = 1'b1;
        end else if (MST_STOP_I) begin
          nxt_st.mst = M_IDLE;
        end
      end
      default: begin
        nxt_st.mst = M_IDLE;
      end
    endcase

    // A general call is recognised through the data phase from CFG_BYTE_SELECT_A set
    // and CFG_GCALL_OR_SBYTE clear while the master is in M_DATA; S_GCD is never entered.
    if (st_ff.mst == M_GCALL && MST_ACK_STB_I && MST_ACKED_I) begin
      nxt_st.sbyte_pend = st_ff.sbyte_pend;
    end
    if ((st_ff.mst == M_GCALL || (st_ff.mst == M_DATA && st_ff.cfg[
         CFG_BYTE_SELECT_A] && ~st_ff.cfg[CFG_GCALL_OR_SBYTE]))
        && CMD_WR_I && CMD_BIT9_I) begin
      set[GCALL_FOLLOWED_BY_READ] = 1'b1;
    end

    if (MST_ARBITRATION_LOST_FLAG_I && st_ff.mst != M_IDLE) begin
      set[ARBITRATION_LOST_FLAG] = 1'b1;
    end

    // Any master cause ends the transfer.
    if (|set) begin
      nxt_st.mst = M_IDLE;
    end

    // Slave state machine, independent of the master one.
    case (st_ff.slv)
      S_IDLE: begin
        if (SLV_RD_REQ_I) begin
          nxt_st.slv = S_TX;
          if (TXF_NOT_EMPTY_I) begin
            set[SLAVE_STALE_FIFO_FLUSH] = 1'b1;
            nxt_st.flush = 1'b1;
          end
        end
      end
      S_TX, S_GCD: begin
        if (CMD_WR_I && CMD_READ_I) begin
          set[SLAVE_READ_CMD_MISUSE] = 1'b1;
        end
        if (scl_rise && SLV_TX_BIT_EN_I
            && (st_ff.sda_s2 != SLV_TX_BIT_I)) begin
          set[SLAVE_BUS_LOST]        = 1'b1;
          set[ARBITRATION_LOST_FLAG] = 1'b1;
          nxt_st.slv = S_IDLE;
        end else if (SLV_TX_DONE_I) begin
          nxt_st.slv = S_IDLE;
        end
      end
      default: begin
        nxt_st.slv = S_IDLE;
      end
    endcase

    // The start byte cause is remembered so that clearing flag 9 without
    // fixing it brings the flag back one cycle later.
    if (set[STARTBYTE_NO_REPEAT]) begin
      nxt_st.sbyte_pend = 1'b1;
    end else if (~sbyte_cause) begin
      nxt_st.sbyte_pend = 1'b0;
    end
    if (st_ff.sbyte_pend && sbyte_cause && ~st_ff.flags[STARTBYTE_NO_REPEAT])
    begin
      set[STARTBYTE_NO_REPEAT] = 1'b1;
    end

    // Set wins over a clear in the same cycle.
    nxt_st.flags = (st_ff.flags & ~clr) | set;
  end

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      st_ff            <= '0;
      st_ff.flags      <= ABORT_RST;
      st_ff.hold       <= SDA_HOLD_RST;
      st_ff.cfg        <= CFG_RST;
      st_ff.mst        <= M_IDLE;
      st_ff.slv        <= S_IDLE;
      st_ff.scl_s1     <= 1'b1;
      st_ff.scl_s2     <= 1'b1;
      st_ff.scl_prev   <= 1'b1;
      st_ff.sda_s1     <= 1'b1;
      st_ff.sda_s2     <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign TRANSMIT_ABORT_EVENT_O = |st_ff.flags;
  assign TXF_FLUSH_O            = st_ff.flush;
  assign SDA_HOLD_COUNT_O       = st_ff.hold;

endmodule : i2c_tx_abort_cause_logic

/* testbench/abort_cause_checker_props.sv */
// Checker of bus timing, abort event, flush pulse and hold register.
`timescale 1ns/1ps
module abort_cause_checker
  import abort_cause_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_B_I,
  // Register bus
  input wire logic [31:0] AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // Slave side and results
  input wire logic        SLV_RD_REQ_I,
  input wire logic        TXF_NOT_EMPTY_I,
  input wire logic        TRANSMIT_ABORT_EVENT_O,
  input wire logic        TXF_FLUSH_O,
  input wire logic [15:0] SDA_HOLD_COUNT_O
);
  logic rd_go;
  logic clr_done;
  logic hold_done;
  logic stale;
  wire  wr_done = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign rd_go = AVS_READ_I && AVS_WAITREQUEST_O;
  assign clr_done = wr_done && AVS_ADDRESS_I == ABORT_CLR_OFF;
  assign hold_done = wr_done && AVS_ADDRESS_I == SDA_HOLD_OFF;
  assign stale = SLV_RD_REQ_I && TXF_NOT_EMPTY_I;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_B_I);
  ////////////////////////////////////////
  AST_ONE_WAIT: assert property ((AVS_READ_I || AVS_WRITE_I) &&
    AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O) else $error("wait too long");
  AST_EVENT_HOLDS: assert property ($fell(TRANSMIT_ABORT_EVENT_O) |->
    $past(clr_done) || $past(clr_done, 2)) else $error("event dropped");
  AST_FLAGS_EVENT: assert property (rd_go &&
    AVS_ADDRESS_I == ABORT_CAUSE_OFF |=> (|AVS_READDATA_O[15:0]) ==
    $past(TRANSMIT_ABORT_EVENT_O)) else $error("event and flags differ");
  AST_STALE_FLUSH: assert property (stale |-> ##[1:2] TXF_FLUSH_O)
    else $error("no flush");
  AST_FLUSH_CAUSE: assert property (TXF_FLUSH_O |-> $past(stale) ||
    $past(stale, 2)) else $error("flush without cause");
  AST_FLUSH_PULSE: assert property (TXF_FLUSH_O |=> !TXF_FLUSH_O)
    else $error("flush too long");
  AST_STALE_EVENT: assert property (stale |-> ##[1:2]
    TRANSMIT_ABORT_EVENT_O) else $error("no event on stale data");
  AST_HOLD_WRITE: assert property (!$stable(SDA_HOLD_COUNT_O) |->
    $past(hold_done)) else $error("hold changed without write");
  AST_READ_STANDS: assert property (!$stable(AVS_READDATA_O) |->
    $past(rd_go)) else $error("read data changed");
endmodule : abort_cause_checker

bind i2c_tx_abort_cause_logic abort_cause_checker i_abort_cause_checker (
  .CLK_I(CLK_I), .RST_B_I(RST_B_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
  .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SLV_RD_REQ_I(SLV_RD_REQ_I), .TXF_NOT_EMPTY_I(TXF_NOT_EMPTY_I),
  .TRANSMIT_ABORT_EVENT_O(TRANSMIT_ABORT_EVENT_O),
  .TXF_FLUSH_O(TXF_FLUSH_O), .SDA_HOLD_COUNT_O(SDA_HOLD_COUNT_O));

/* testbench/bus_peer.sv */
// Far-side bus peer: link clock source and open-drain data line.
`timescale 1ns/1ps
module bus_peer (
  // Control from the bench
  input  wire logic frame_i,
  input  wire logic pull_low_i,
  // Bit the block intends to send
  input  wire logic bit_en_i,
  input  wire logic bit_i,
  // Bus lines
  output logic      scl_o,
  output logic      sda_o
);
  // The clock stands high between frames, so no stray edges are seen.
  initial begin
    scl_o = 1'b1;
    forever begin
      #80;
      scl_o = frame_i ? ~scl_o : 1'b1;
    end
  end
  // Pull-up with wired-AND: a peer pulling low overrides the block's bit.
  assign sda_o = (~bit_en_i | bit_i) & ~pull_low_i;
endmodule : bus_peer

/* testbench/tb_i2c_tx_abort_cause_logic.sv */
// Self-checking bench for the transmit abort cause logic.
`timescale 1ns/1ps
module tb_i2c_tx_abort_cause_logic;
  import abort_cause_pkg::*;
  typedef struct packed {
    logic [5:0]  cfg;
    logic [2:0]  flg;
    logic [1:0]  n;
    logic [1:0]  ack;
    logic [15:0] exp;
  } row_s;
  // Config, {read bit, bit 9 write, arbitration loss}, acks, flags.
  row_s        rows [15] = '{
    '{6'h03,3'h0,2'h1,2'h0,16'h0001}, '{6'h03,3'h0,2'h2,2'h1,16'h0008},
    '{6'h07,3'h0,2'h1,2'h0,16'h0002}, '{6'h07,3'h0,2'h2,2'h1,16'h0004},
    '{6'h13,3'h0,2'h1,2'h0,16'h0010}, '{6'h13,3'h2,2'h0,2'h0,16'h0020},
    '{6'h33,3'h0,2'h1,2'h1,16'h0080}, '{6'h0b,3'h0,2'h1,2'h1,16'h0040},
    '{6'h02,3'h0,2'h0,2'h0,16'h0800}, '{6'h38,3'h0,2'h0,2'h0,16'h0800},
    '{6'h05,3'h4,2'h0,2'h0,16'h0400}, '{6'h31,3'h0,2'h0,2'h0,16'h0200},
    '{6'h09,3'h0,2'h0,2'h0,16'h0100}, '{6'h03,3'h1,2'h0,2'h0,16'h1000},
    '{6'h03,3'h0,2'h2,2'h3,16'h0000}};
  logic        clk, rst_b, rd, wr, waitreq, ev, flush, scl, sda;
  logic        cmd_rd, cmd_b9, acked, txf_ne, bit_en, tx_bit, frame, pull;
  logic [4:0]  pls;
  logic [15:0] q, hold;
  logic [31:0] adr, wdat, rdat;
  int          bad_count, comparisons;

  i2c_tx_abort_cause_logic i_i2c_tx_abort_cause_logic (
    .CLK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat), .AVS_BYTEENABLE_I(4'hf),
    .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(waitreq), .SCL_I(scl),
    .SDA_I(sda), .CMD_WR_I(pls[0]), .CMD_READ_I(cmd_rd),
    .CMD_BIT9_I(cmd_b9), .MST_ACK_STB_I(pls[1]), .MST_ACKED_I(acked),
    .MST_ARBITRATION_LOST_FLAG_I(pls[2]), .MST_STOP_I(1'b0), .SLV_RD_REQ_I(pls[3]),
    .TXF_NOT_EMPTY_I(txf_ne), .SLV_TX_BIT_EN_I(bit_en),
    .SLV_TX_BIT_I(tx_bit), .SLV_TX_DONE_I(pls[4]),
    .TRANSMIT_ABORT_EVENT_O(ev), .TXF_FLUSH_O(flush),
    .SDA_HOLD_COUNT_O(hold));
  bus_peer i_bus_peer (.frame_i(frame), .pull_low_i(pull), .bit_en_i(bit_en),
    .bit_i(tx_bit), .scl_o(scl), .sda_o(sda));

  ////////////////////////////////////////
  task automatic check(input string what, input logic [15:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic pulse(input int i);
    @(posedge clk);
    pls[i] <= 1'b1;
    @(posedge clk);
    pls <= 5'h00;
  endtask : pulse

  // Request held until waitrequest is seen low; data taken at that edge.
  task automatic bus(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    q = rdat[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic rdreg(input logic [31:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rdreg

  task automatic do_reset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset

  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end

  initial begin
    {rst_b, rd, wr, cmd_rd, cmd_b9, acked, txf_ne, bit_en} = 8'h00;
    {tx_bit, frame, pull, pls, adr, wdat} = 72'h0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      do_reset(1);
      bus(1'b1, CTRL_CFG_OFF, {26'h0, rows[i].cfg});
      cmd_rd <= rows[i].flg[2];
      pulse(0);
      cmd_rd <= 1'b0;
      cmd_b9 <= rows[i].flg[1];
      if (rows[i].flg[1]) pulse(0);
      cmd_b9 <= 1'b0;
      for (int k = 0; k < rows[i].n; k++) begin
        acked <= rows[i].ack[k];
        pulse(1);
      end
      if (rows[i].flg[0]) pulse(2);
      rdreg(ABORT_CAUSE_OFF);
      check("flags", q, rows[i].exp);
      check("event", {15'h0, ev}, {15'h0, |rows[i].exp});
      bus(1'b1, ABORT_CLR_OFF, 32'h0);
      rdreg(ABORT_CAUSE_OFF);
      check("cleared", q, rows[i].cfg == 6'h31 ? 16'h0200 : 16'h0);
      bus(1'b1, CTRL_CFG_OFF, 32'h3);
      bus(1'b1, ABORT_CLR_OFF, 32'h0);
      rdreg(ABORT_CAUSE_OFF);
      check("fixed", q, 16'h0000);
    end
    do_reset(6);
    rdreg(SDA_HOLD_OFF);
    check("hold reset", q, SDA_HOLD_RST);
    rdreg(ABORT_CAUSE_OFF);
    check("flag reset", q, ABORT_RST);
    bus(1'b1, ABORT_CAUSE_OFF, 32'hffff);
    rdreg(ABORT_CAUSE_OFF);
    check("read only", q, 16'h0000);
    rdreg(32'h5000_1600);
    check("unmapped", q, 16'h0000);
    bus(1'b1, SDA_HOLD_OFF, 32'ha5c3);
    rdreg(SDA_HOLD_OFF);
    check("hold", q, 16'ha5c3);
    check("hold pin", hold, 16'ha5c3);
    // Master busy while the slave meets stale data: both causes recorded.
    pulse(0);
    txf_ne <= 1'b1;
    pulse(3);
    txf_ne <= 1'b0;
    acked <= 1'b0;
    pulse(1);
    rdreg(ABORT_CAUSE_OFF);
    check("stale", q, 16'h2001);
    do_reset(1);
    pulse(3);
    cmd_rd <= 1'b1;
    pulse(0);
    cmd_rd <= 1'b0;
    rdreg(ABORT_CAUSE_OFF);
    check("misuse", q, 16'h8000);
    for (int f = 0; f < 2; f++) begin
      do_reset(1);
      pulse(3);
      bit_en <= 1'b1;
      tx_bit <= 1'b1;
      pull <= f[0];
      frame <= 1'b1;
      repeat (30) @(posedge clk);
      frame <= 1'b0;
      repeat (10) @(posedge clk);
      bit_en <= 1'b0;
      pull <= 1'b0;
      pulse(4);
      rdreg(ABORT_CAUSE_OFF);
      check("bus lost", q, f ? 16'h5000 : 16'h0000);
    end
    complete_run();
  end
endmodule : tb_i2c_tx_abort_cause_logic
